// File: include/ssu_pkg.sv
package ssu_pkg;

	// ==========================================================================
	// Serial frame layout
	// ==========================================================================
	localparam int          SSU_ADDR_W     = 9;
	localparam int          SSU_DATA_W     = 16;
	localparam int          SSU_FRAME_W    = SSU_ADDR_W + 1 + SSU_DATA_W;
	localparam logic [4:0]  SSU_FRAME_LAST = 5'h19;
	localparam logic        SSU_WR_FLAG    = 1'h1;
	localparam logic        SSU_RD_FLAG    = 1'h0;

	// ==========================================================================
	// Sensor register addresses
	// ==========================================================================
	localparam logic [8:0] SSU_A_CLKGEN_RST  = 9'h009;
	localparam logic [8:0] SSU_A_GLOBAL_RST  = 9'h00A;
	localparam logic [8:0] SSU_A_CLK_DIST    = 9'h020;
	localparam logic [8:0] SSU_A_COL_MUX_EN  = 9'h028;
	localparam logic [8:0] SSU_A_IMG_CORE    = 9'h029;
	localparam logic [8:0] SSU_A_FRONT_EN    = 9'h030;
	localparam logic [8:0] SSU_A_BIAS_EN     = 9'h040;
	localparam logic [8:0] SSU_A_OUT_DRV     = 9'h070;
	localparam logic [8:0] SSU_A_BLACK_CAL   = 9'h080;
	localparam logic [8:0] SSU_A_DATA_WIDTH  = 9'h081;
	localparam logic [8:0] SSU_A_SEQ_CTRL    = 9'h0C0;
	// Lock-detect status location; arbitrary placement
	localparam logic [8:0] SSU_A_PLL_STATUS  = 9'h018;
	localparam int         SSU_LOCK_BIT      = 0;

	// ==========================================================================
	// Data values and masks
	// ==========================================================================
	localparam logic [15:0] SSU_ZERO        = 16'h0000;
	localparam logic [15:0] SSU_CLK_BASE    = 16'h2002;
	localparam logic [15:0] SSU_CLK_8BIT    = 16'h0008;
	localparam logic [15:0] SSU_CLK_PLL     = 16'h0004;
	localparam logic [15:0] SSU_CLK_ANALOG  = 16'h0001;
	localparam logic [15:0] SSU_TX_SERIAL   = 16'h0007;
	localparam logic [15:0] SSU_TX_PARALLEL = 16'h0000;
	localparam logic [15:0] SSU_WIDTH_MASK  = 16'h2000;
	localparam logic [15:0] SSU_SEQEN_MASK  = 16'h0001;
	localparam logic [15:0] SSU_IMG_CORE_V  = 16'h085A;
	localparam logic [15:0] SSU_BLACK_CAL_V = 16'h4710;

	// ==========================================================================
	// Upload sequence: clock part 2, fixed uploads, soft power up, enable
	// ==========================================================================
	localparam int         SSU_SEQ_N      = 71;
	localparam logic [6:0] SSU_IDX_CLK2   = 7'h01;
	localparam logic [6:0] SSU_IDX_WIDTH  = 7'h04;
	localparam logic [6:0] SSU_IDX_PU_CLK = 7'h3F;
	localparam logic [6:0] SSU_IDX_TX     = 7'h45;
	localparam logic [6:0] SSU_IDX_ENABLE = 7'h46;
	localparam logic [6:0] SSU_IDX_LAST   = 7'h46;

	localparam logic [24:0] SSU_SEQ [0:SSU_SEQ_N-1] = '{
		{9'h009, 16'h0000}, {9'h020, 16'h200E}, {9'h022, 16'h0001},
		{9'h029, 16'h085A}, {9'h081, 16'h0000}, {9'h041, 16'h288B}, {9'h042, 16'h53C5},
		{9'h043, 16'h0344}, {9'h044, 16'h0085}, {9'h046, 16'h4800}, {9'h080, 16'h4710},
		{9'h0C5, 16'h0103}, {9'h0B0, 16'h00F5}, {9'h0B4, 16'h00FD}, {9'h0B5, 16'h0144},
		{9'h183, 16'h549F}, {9'h184, 16'h549F}, {9'h185, 16'h5091}, {9'h186, 16'h1011},
		{9'h187, 16'h111F}, {9'h188, 16'h1110}, {9'h1AF, 16'h0356}, {9'h1B0, 16'h0141},
		{9'h1B1, 16'h214F}, {9'h1B2, 16'h214A}, {9'h1B3, 16'h2101}, {9'h1B4, 16'h0101},
		{9'h1B5, 16'h0B85}, {9'h1B6, 16'h0381}, {9'h1B7, 16'h0181}, {9'h1B8, 16'h218F},
		{9'h1B9, 16'h218A}, {9'h1BA, 16'h2101}, {9'h1BB, 16'h0100}, {9'h1BF, 16'h0B55},
		{9'h1C0, 16'h0351}, {9'h1C1, 16'h0141}, {9'h1C2, 16'h214F}, {9'h1C3, 16'h214A},
		{9'h1C4, 16'h2101}, {9'h1C5, 16'h0101}, {9'h1C6, 16'h0B85}, {9'h1C7, 16'h0381},
		{9'h1C8, 16'h0181}, {9'h1C9, 16'h218F}, {9'h1CA, 16'h218A}, {9'h1CB, 16'h2101},
		{9'h1CC, 16'h0100}, {9'h1D5, 16'h2184}, {9'h1D8, 16'h1347}, {9'h1DC, 16'h2144},
		{9'h1E0, 16'h8D04}, {9'h1E1, 16'h8501}, {9'h1E4, 16'hCD04}, {9'h1E5, 16'hC501},
		{9'h1E9, 16'h0BE2}, {9'h1ED, 16'h2184}, {9'h1F0, 16'h1347}, {9'h1F4, 16'h2144},
		{9'h1F8, 16'h8D04}, {9'h1F9, 16'h8501}, {9'h1FC, 16'hCD04}, {9'h1FD, 16'hC501},
		{9'h020, 16'h200F}, {9'h00A, 16'h0000}, {9'h040, 16'h0001}, {9'h048, 16'h0203},
		{9'h028, 16'h0003}, {9'h030, 16'h0001}, {9'h070, 16'h0007},
		{9'h0C0, 16'h0001}
	};

	// ==========================================================================
	// State encodings (Gray along the listed order)
	// ==========================================================================
	typedef enum logic [2:0] {
		SSU_IDLE      = 3'h0,
		SSU_LOCK_REQ  = 3'h1,
		SSU_LOCK_WAIT = 3'h3,
		SSU_ISSUE     = 3'h2,
		SSU_RD_WAIT   = 3'h6,
		SSU_WR_WAIT   = 3'h7
	} ssu_ctl_e;

	typedef enum logic [2:0] {
		SSU_SPI_IDLE  = 3'h0,
		SSU_SPI_LEAD  = 3'h1,
		SSU_SPI_SHIFT = 3'h3,
		SSU_SPI_TRAIL = 3'h2,
		SSU_SPI_GAP   = 3'h6
	} ssu_spi_e;

endpackage : ssu_pkg

// File: core/ssu_spi.sv
`timescale 1ns/1ps
module ssu_spi #(
	parameter int CLK_DIV = 4
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        req,
	input  wire logic        wr,
	input  wire logic [8:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        miso,
	output logic             ack,
	output logic [15:0]      rdata,
	output logic             sclk,
	output logic             ss_n,
	output logic             mosi
);

	// Read data needs half a serial period to cover the two-stage synchroniser
	if (CLK_DIV < 4 || CLK_DIV > 256) begin : g_bad_div
		$error("ssu_spi: CLK_DIV must lie in 4..256");
	end

	typedef struct packed {
		ssu_pkg::ssu_spi_e st;
		logic [7:0]        div;
		logic [25:0]       sh;
		logic [4:0]        cnt;
		logic              sclk;
		logic              ss_n;
		logic              mosi;
		logic [15:0]       rd;
		logic              ack;
		logic              miso_s1;
		logic              miso_s2;
	} ssu_spi_s;

	ssu_spi_s s_q;
	ssu_spi_s s_d;
	logic     tick;

	// ==========================================================================
	// Frame engine
	// ==========================================================================
	always_comb begin
		s_d         = s_q;
		s_d.ack     = 1'h0;
		s_d.miso_s1 = miso;
		s_d.miso_s2 = s_q.miso_s1;
		tick        = (s_q.div == 8'(CLK_DIV - 1));
		s_d.div     = tick ? 8'h00 : s_q.div + 8'h01;
		case (s_q.st)
			ssu_pkg::SSU_SPI_IDLE: begin
				s_d.div = 8'h00;
				if (req) begin
					s_d.sh   = {addr, wr, wdata};
					s_d.mosi = addr[8];
					s_d.ss_n = 1'h0;
					s_d.cnt  = 5'h00;
					s_d.st   = ssu_pkg::SSU_SPI_LEAD;
				end
			end
			ssu_pkg::SSU_SPI_LEAD: begin
				if (tick) begin
					s_d.st = ssu_pkg::SSU_SPI_SHIFT;
				end
			end
			ssu_pkg::SSU_SPI_SHIFT: begin
				if (tick && !s_q.sclk) begin
					s_d.sclk = 1'h1;
					s_d.rd   = {s_q.rd[14:0], s_q.miso_s2};
				end else if (tick) begin
					s_d.sclk = 1'h0;
					if (s_q.cnt == ssu_pkg::SSU_FRAME_LAST) begin
						s_d.st = ssu_pkg::SSU_SPI_TRAIL;
					end else begin
						s_d.cnt  = s_q.cnt + 5'h01;
						s_d.sh   = {s_q.sh[24:0], 1'h0};
						s_d.mosi = s_q.sh[24];
					end
				end
			end
			ssu_pkg::SSU_SPI_TRAIL: begin
				if (tick) begin
					s_d.ss_n = 1'h1;
					s_d.mosi = 1'h0;
					s_d.st   = ssu_pkg::SSU_SPI_GAP;
				end
			end
			ssu_pkg::SSU_SPI_GAP: begin
				// Chip select stays high at least half a serial period so frames never merge
				if (tick) begin
					s_d.ack = 1'h1;
					s_d.st  = ssu_pkg::SSU_SPI_IDLE;
				end
			end
			default: begin
				s_d.st = ssu_pkg::SSU_SPI_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '{st: ssu_pkg::SSU_SPI_IDLE, ss_n: 1'h1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign ack   = s_q.ack;
	assign rdata = s_q.rd;
	assign sclk  = s_q.sclk;
	assign ss_n  = s_q.ss_n;
	assign mosi  = s_q.mosi;

endmodule : ssu_spi

// File: core/ssu_loader.sv
// Overview of operation
// [R1] Parallel clock part 2: 9, 32, 34.
// [R2] Fixed reserved uploads in listed order.
// [R3] Calibration, exposure, sequencer program exactly.
// [R4] Register 129 bit 13 selects width.
// [R5] Power up starts with mode clock value.
// [R6] Then release soft reset, register 10.
// [R7] Enable bias, pump, multiplexer, front end.
// [R8] Register 112 last, serial or parallel.
// [R9] Set sequencer enable bit to start.
// [R10] Preserve other bits of register 192.
// [R11] Every action is single ordered writes.
// [R12] PLL serial modes wait for lock.
// [R13] Clearing enable bit stops the sequencer.
// [R14] One write completes before the next.
`timescale 1ns/1ps
module ssu_loader #(
	parameter int CLK_DIV = 4
) (
	input  wire logic CLK,
	input  wire logic SYS_RST,
	input  wire logic START,
	input  wire logic STOP,
	input  wire logic MODE_8BIT,
	input  wire logic MODE_PLL,
	input  wire logic MODE_PARALLEL,
	input  wire logic SPI_MISO,
	output logic      BUSY,
	output logic      DONE,
	output logic      ERR,
	output logic      RUNNING,
	output logic      SPI_SS_N,
	output logic      SPI_SCLK,
	output logic      SPI_MOSI
);

	// The serial engine refuses the same range; caught here so the top fails first
	if (CLK_DIV < 4 || CLK_DIV > 256) begin : g_bad_div
		$error("ssu_loader: CLK_DIV must lie in 4..256");
	end

	typedef struct packed {
		ssu_pkg::ssu_ctl_e st;
		logic [6:0]        idx;
		logic [15:0]       rd;
		logic              req;
		logic              wr;
		logic [8:0]        addr;
		logic [15:0]       wdata;
		logic              busy;
		logic              done;
		logic              err;
		logic              running;
		logic              stopping;
		logic              m8;
		logic              pll;
		logic              par;
		logic              lock_seen;
		logic [8:0]        last_addr;
		logic [8:0]        prev_addr;
	} ssu_ctl_s;

	ssu_ctl_s    s_q;
	ssu_ctl_s    s_d;
	logic        spi_ack;
	logic [15:0] spi_rdata;
	logic [24:0] entry;
	logic [15:0] mask;

	// ==========================================================================
	// Table decoding
	// ==========================================================================
	function automatic logic [15:0] clk_cfg(input logic m8, input logic pll);
		clk_cfg = ssu_pkg::SSU_CLK_BASE | (m8 ? ssu_pkg::SSU_CLK_8BIT : ssu_pkg::SSU_ZERO)
			| (pll ? ssu_pkg::SSU_CLK_PLL : ssu_pkg::SSU_ZERO);
	endfunction : clk_cfg

	function automatic logic [15:0] rmw_mask(input logic [6:0] idx);
		case (idx)
			ssu_pkg::SSU_IDX_WIDTH: rmw_mask = ssu_pkg::SSU_WIDTH_MASK;
			ssu_pkg::SSU_IDX_ENABLE: rmw_mask = ssu_pkg::SSU_SEQEN_MASK;
			default: rmw_mask = ssu_pkg::SSU_ZERO;
		endcase
	endfunction : rmw_mask

	// Mode-dependent entries override the stored word; the rest go out verbatim
	function automatic logic [24:0] entry_of(input ssu_ctl_s s);
		logic [24:0] e;
		logic        m8c;
		logic        pllc;
		e    = ssu_pkg::SSU_SEQ[s.idx]; // R2 R3 R6 R7
		m8c  = s.m8 | s.par;
		pllc = s.pll | s.par;
		case (s.idx)
			ssu_pkg::SSU_IDX_CLK2: e[15:0] = clk_cfg(m8c, pllc); // R1
			ssu_pkg::SSU_IDX_WIDTH: e[15:0] = s.m8 ? ssu_pkg::SSU_WIDTH_MASK : ssu_pkg::SSU_ZERO; // R4
			ssu_pkg::SSU_IDX_PU_CLK: e[15:0] = clk_cfg(m8c, pllc) | ssu_pkg::SSU_CLK_ANALOG; // R5
			ssu_pkg::SSU_IDX_TX: e[15:0] = s.par ? ssu_pkg::SSU_TX_PARALLEL : ssu_pkg::SSU_TX_SERIAL; // R8
			ssu_pkg::SSU_IDX_ENABLE: e[15:0] = s.stopping ? ssu_pkg::SSU_ZERO : ssu_pkg::SSU_SEQEN_MASK; // R9 R13
			default: e = e;
		endcase
		entry_of = e;
	endfunction : entry_of

	// ==========================================================================
	// Sequencer
	// ==========================================================================
	always_comb begin
		s_d      = s_q;
		s_d.req  = 1'h0;
		s_d.done = 1'h0;
		s_d.err  = 1'h0;
		entry    = entry_of(s_q);
		mask     = rmw_mask(s_q.idx);
		case (s_q.st)
			ssu_pkg::SSU_IDLE: begin
				if (START && MODE_PARALLEL && MODE_8BIT) begin
					// The parallel variant only offers 10-bit output
					s_d.err = 1'h1;
				end else if (START) begin
					s_d.m8        = MODE_8BIT;
					s_d.pll       = MODE_PLL;
					s_d.par       = MODE_PARALLEL;
					s_d.idx       = '0;
					s_d.busy      = 1'h1;
					s_d.stopping  = 1'h0;
					s_d.running   = 1'h0;
					s_d.lock_seen = 1'h0;
					s_d.st = (MODE_PLL && !MODE_PARALLEL) ? ssu_pkg::SSU_LOCK_REQ : ssu_pkg::SSU_ISSUE; // R12
				end else if (STOP && s_q.running) begin
					s_d.idx      = ssu_pkg::SSU_IDX_ENABLE; // R13
					s_d.stopping = 1'h1;
					s_d.busy     = 1'h1;
					s_d.st       = ssu_pkg::SSU_ISSUE;
				end
			end
			ssu_pkg::SSU_LOCK_REQ: begin
				s_d.req  = 1'h1;
				s_d.wr   = ssu_pkg::SSU_RD_FLAG;
				s_d.addr = ssu_pkg::SSU_A_PLL_STATUS;
				s_d.st   = ssu_pkg::SSU_LOCK_WAIT;
			end
			ssu_pkg::SSU_LOCK_WAIT: begin
				if (spi_ack && spi_rdata[ssu_pkg::SSU_LOCK_BIT]) begin
					s_d.lock_seen = 1'h1; // R12
					s_d.st        = ssu_pkg::SSU_ISSUE;
				end else if (spi_ack) begin
					s_d.st = ssu_pkg::SSU_LOCK_REQ;
				end
			end
			ssu_pkg::SSU_ISSUE: begin
				s_d.req  = 1'h1; // R11
				s_d.addr = entry[24:16];
				if (mask != ssu_pkg::SSU_ZERO) begin
					s_d.wr = ssu_pkg::SSU_RD_FLAG;
					s_d.st = ssu_pkg::SSU_RD_WAIT;
				end else begin
					s_d.wr        = ssu_pkg::SSU_WR_FLAG;
					s_d.wdata     = entry[15:0];
					s_d.prev_addr = s_q.last_addr;
					s_d.last_addr = entry[24:16];
					s_d.st        = ssu_pkg::SSU_WR_WAIT;
				end
			end
			ssu_pkg::SSU_RD_WAIT: begin
				if (spi_ack) begin
					// Keep every other bit of the word as the sensor holds it
					s_d.rd        = spi_rdata;
					s_d.req       = 1'h1;
					s_d.wr        = ssu_pkg::SSU_WR_FLAG;
					s_d.wdata     = (spi_rdata & ~mask) | (entry[15:0] & mask); // R4 R10
					s_d.prev_addr = s_q.last_addr;
					s_d.last_addr = s_q.addr;
					s_d.st        = ssu_pkg::SSU_WR_WAIT;
				end
			end
			ssu_pkg::SSU_WR_WAIT: begin
				if (spi_ack && (s_q.stopping || s_q.idx == ssu_pkg::SSU_IDX_LAST)) begin
					s_d.busy    = 1'h0;
					s_d.done    = 1'h1;
					s_d.running = !s_q.stopping; // R9
					s_d.st      = ssu_pkg::SSU_IDLE;
				end else if (spi_ack) begin
					s_d.idx = s_q.idx + 7'h01; // R14
					s_d.st  = ssu_pkg::SSU_ISSUE;
				end
			end
			default: begin
				s_d.st = ssu_pkg::SSU_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s_q <= '{st: ssu_pkg::SSU_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================================
	// Serial port
	// ==========================================================================
	ssu_spi #(
		.CLK_DIV(CLK_DIV)
	) u_spi (
		.clk   (CLK),
		.rst   (SYS_RST),
		.req   (s_q.req),
		.wr    (s_q.wr),
		.addr  (s_q.addr),
		.wdata (s_q.wdata),
		.miso  (SPI_MISO),
		.ack   (spi_ack),
		.rdata (spi_rdata),
		.sclk  (SPI_SCLK),
		.ss_n  (SPI_SS_N),
		.mosi  (SPI_MOSI)
	);

	assign BUSY    = s_q.busy;
	assign DONE    = s_q.done;
	assign ERR     = s_q.err;
	assign RUNNING = s_q.running;

	// ==========================================================================
	// Checks
	// ==========================================================================
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);

	logic wr_go;
	assign wr_go = s_q.req && s_q.wr;

	clk_part2_order_a: assert property (wr_go && s_q.idx == ssu_pkg::SSU_IDX_CLK2 |-> // R1
		s_q.prev_addr == ssu_pkg::SSU_A_CLKGEN_RST && s_q.wdata == clk_cfg(s_q.m8 | s_q.par, s_q.pll | s_q.par))
		else $error("clock part 2 write out of order or wrong value");
	core_value_a: assert property (wr_go && s_q.addr == ssu_pkg::SSU_A_IMG_CORE |-> // R2
		s_q.wdata == ssu_pkg::SSU_IMG_CORE_V)
		else $error("image core value wrong");
	black_cal_a: assert property (wr_go && s_q.addr == ssu_pkg::SSU_A_BLACK_CAL |-> // R3
		s_q.wdata == ssu_pkg::SSU_BLACK_CAL_V)
		else $error("black calibration value wrong");
	width_bit_a: assert property (wr_go && s_q.addr == ssu_pkg::SSU_A_DATA_WIDTH |-> // R4
		s_q.wdata[13] == s_q.m8 && s_q.wdata[12:0] == s_q.rd[12:0])
		else $error("data width bit wrong");
	pu_first_a: assert property (wr_go && s_q.addr == ssu_pkg::SSU_A_GLOBAL_RST |-> // R5
		s_q.prev_addr == ssu_pkg::SSU_A_CLK_DIST && s_q.wdata == ssu_pkg::SSU_ZERO)
		else $error("soft reset release not preceded by clock distribution");
	bias_after_rst_a: assert property (wr_go && s_q.addr == ssu_pkg::SSU_A_BIAS_EN |-> // R6
		s_q.prev_addr == ssu_pkg::SSU_A_GLOBAL_RST)
		else $error("biasing enabled before soft reset release");
	front_after_mux_a: assert property (wr_go && s_q.addr == ssu_pkg::SSU_A_FRONT_EN |-> // R7
		s_q.prev_addr == ssu_pkg::SSU_A_COL_MUX_EN)
		else $error("front end enabled out of order");
	tx_value_a: assert property (wr_go && s_q.addr == ssu_pkg::SSU_A_OUT_DRV |-> // R8
		s_q.prev_addr == ssu_pkg::SSU_A_FRONT_EN
		&& s_q.wdata == (s_q.par ? ssu_pkg::SSU_TX_PARALLEL : ssu_pkg::SSU_TX_SERIAL))
		else $error("output driver write wrong");
	seq_enable_a: assert property (wr_go && s_q.addr == ssu_pkg::SSU_A_SEQ_CTRL |-> // R9
		s_q.wdata[0] == !s_q.stopping ##[1:400] s_q.done && s_q.running == !s_q.stopping)
		else $error("sequencer enable write or completion wrong");
	keep_mode_a: assert property (wr_go && s_q.addr == ssu_pkg::SSU_A_SEQ_CTRL |-> // R10
		s_q.wdata[15:1] == s_q.rd[15:1] && $past(s_q.st) == ssu_pkg::SSU_RD_WAIT)
		else $error("mode bits of sequencer control not preserved");
	one_write_a: assert property (s_q.req |=> !s_q.req [*8]) // R11 R14
		else $error("serial requests overlap");
	lock_first_a: assert property (wr_go && s_q.idx == ssu_pkg::SSU_IDX_CLK2 && s_q.pll && !s_q.par |-> // R12
		s_q.lock_seen)
		else $error("clock part 2 issued before lock");

	// ==========================================================================
	// Sequencing checks
	// ==========================================================================
	logic_en_order_a: assert property (wr_go && s_q.idx == ssu_pkg::SSU_IDX_CLK2 + 7'h01 |-> // R1
		s_q.prev_addr == ssu_pkg::SSU_A_CLK_DIST)
		else $error("logic block enable not after clock distribution");
	pu_clock_a: assert property (wr_go && s_q.idx == ssu_pkg::SSU_IDX_PU_CLK |-> // R5
		s_q.wdata == (clk_cfg(s_q.m8 | s_q.par, s_q.pll | s_q.par) | ssu_pkg::SSU_CLK_ANALOG))
		else $error("analog clock distribution value wrong");
	refuse_mode_a: assert property (s_q.st == ssu_pkg::SSU_IDLE && START && MODE_PARALLEL && MODE_8BIT |=> // R4
		s_q.err && !s_q.busy)
		else $error("8-bit parallel start not refused");
	rmw_read_a: assert property (s_q.req && !s_q.wr && s_q.addr != ssu_pkg::SSU_A_PLL_STATUS |-> // R10
		s_q.addr == ssu_pkg::SSU_A_DATA_WIDTH || s_q.addr == ssu_pkg::SSU_A_SEQ_CTRL)
		else $error("unexpected read-modify-write target");
	req_when_busy_a: assert property (s_q.req |-> s_q.busy) // R11
		else $error("serial request outside an operation");
	poll_mode_a: assert property (s_q.req && !s_q.wr && s_q.addr == ssu_pkg::SSU_A_PLL_STATUS |-> // R12
		s_q.pll && !s_q.par)
		else $error("lock status polled in a mode without lock detect");
	stop_path_a: assert property (s_q.st == ssu_pkg::SSU_IDLE && !START && STOP && s_q.running |=> // R13
		s_q.stopping && s_q.busy && s_q.idx == ssu_pkg::SSU_IDX_ENABLE)
		else $error("stop request not taken");
	done_idle_a: assert property (s_q.done |-> !s_q.busy && s_q.st == ssu_pkg::SSU_IDLE) // R9
		else $error("completion flagged while busy");
	idle_quiet_a: assert property (s_q.st == ssu_pkg::SSU_IDLE |-> !s_q.req) // R14
		else $error("request raised from idle");

endmodule : ssu_loader

// File: test/ssu_sensor_model.sv
`timescale 1ns/1ps
module ssu_sensor_model (
	input  wire logic        rst,
	input  wire logic [15:0] pre129,
	input  wire logic [15:0] pre192,
	input  wire logic [1:0]  lock_after,
	input  wire logic        ss_n,
	input  wire logic        sclk,
	input  wire logic        mosi,
	output logic             miso,
	output logic             wr_tgl,
	output logic [8:0]       wr_addr,
	output logic [15:0]      wr_data,
	output logic             seq_on,
	output logic             width8,
	output logic [7:0]       polls,
	output logic             lock_seen
);
	// ==========================================================
	// Register file and serial slave
	// ==========================================================
	logic [15:0] regs [0:511];
	logic [25:0] sh;
	logic [15:0] rd;
	logic        rdf;
	int          cnt;

	initial begin
		miso = 1'h0;
		wr_tgl = 1'h0;
		polls = 8'h0;
		lock_seen = 1'h0;
		cnt = 0;
		rdf = 1'h0;
	end

	assign seq_on = regs[192][0];
	assign width8 = regs[129][13];

	// Presets load at release so mode bits other than bit 0 are random
	always @(negedge rst) begin
		regs[129] = pre129;
		regs[192] = pre192;
		polls = 8'h0;
		lock_seen = 1'h0;
		cnt = 0;
	end

	always @(negedge ss_n) begin
		cnt = 0;
		rdf = 1'h0;
	end

	always @(posedge sclk) if (!ss_n && !rst) begin
		sh = {sh[24:0], mosi};
		cnt++;
		if (cnt == 10 && !mosi) begin
			rdf = 1'h1;
			rd = regs[sh[9:1]];
			if (sh[9:1] == ssu_pkg::SSU_A_PLL_STATUS) begin
				polls++;
				rd = 16'h0;
				rd[ssu_pkg::SSU_LOCK_BIT] = polls > {6'h0, lock_after};
				lock_seen = lock_seen | rd[ssu_pkg::SSU_LOCK_BIT];
			end
		end
	end

	always @(negedge sclk) if (!ss_n && rdf && cnt < 26) begin
		miso = rd[25 - cnt];
	end

	// Released line shows the inverse so a late sample cannot match by luck
	always @(posedge ss_n) if (!rst) begin
		miso = ~miso;
		if (cnt == 26 && sh[16]) begin
			regs[sh[25:17]] = sh[15:0];
			wr_addr = sh[25:17];
			wr_data = sh[15:0];
			wr_tgl = ~wr_tgl;
		end
	end
endmodule : ssu_sensor_model

// File: test/ssu_loader_test.sv
`timescale 1ns/1ps
module ssu_loader_test;
	// ==========================================================
	// Signals
	// ==========================================================
	logic        CLK = 1'h0;
	logic        SYS_RST = 1'h1;
	logic        START = 1'h0;
	logic        STOP = 1'h0;
	logic        MODE_8BIT = 1'h0;
	logic        MODE_PLL = 1'h0;
	logic        MODE_PARALLEL = 1'h0;
	logic        SPI_MISO, BUSY, DONE, ERR, RUNNING, SPI_SS_N, SPI_SCLK, SPI_MOSI;
	logic        wr_tgl, seq_on, width8, lock_seen, stopping = 1'h0;
	logic [8:0]  wr_addr;
	logic [15:0] wr_data, p129 = 16'h0, p192 = 16'h0;
	logic [7:0]  polls;
	logic [1:0]  lk = 2'h0;
	logic [31:0] seed = 32'h00014D84;
	int          wi = 0, fails = 0, cmp_count = 0;

	always #20 CLK = ~CLK;

	ssu_loader #(.CLK_DIV(4)) DUT (.CLK(CLK), .SYS_RST(SYS_RST), .START(START), .STOP(STOP),
		.MODE_8BIT(MODE_8BIT), .MODE_PLL(MODE_PLL), .MODE_PARALLEL(MODE_PARALLEL), .SPI_MISO(SPI_MISO),
		.BUSY(BUSY), .DONE(DONE), .ERR(ERR), .RUNNING(RUNNING), .SPI_SS_N(SPI_SS_N),
		.SPI_SCLK(SPI_SCLK), .SPI_MOSI(SPI_MOSI));

	ssu_sensor_model sensor (.rst(SYS_RST), .pre129(p129), .pre192(p192), .lock_after(lk),
		.ss_n(SPI_SS_N), .sclk(SPI_SCLK), .mosi(SPI_MOSI), .miso(SPI_MISO), .wr_tgl(wr_tgl),
		.wr_addr(wr_addr), .wr_data(wr_data), .seq_on(seq_on), .width8(width8), .polls(polls),
		.lock_seen(lock_seen));

	// ==========================================================
	// Helpers
	// ==========================================================
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [24:0] exp_wr(int i);
		logic [15:0] ck;
		ck = MODE_PARALLEL ? 16'h200E : (16'h2002 | {12'h0, MODE_8BIT, MODE_PLL, 2'h0});
		case (i)
			0: return {9'h009, 16'h0000};
			1: return {9'h020, ck};
			2: return {9'h022, 16'h0001};
			3: return {9'h029, 16'h085A};
			4: return {9'h081, (p129 & 16'hDFFF) | {2'h0, MODE_8BIT, 13'h0}};
			5: return {9'h041, 16'h288B};
			6: return {9'h042, 16'h53C5};
			10: return {9'h080, 16'h4710};
			11: return {9'h0C5, 16'h0103};
			63: return {9'h020, ck | 16'h0001};
			64: return {9'h00A, 16'h0000};
			65: return {9'h040, 16'h0001};
			66: return {9'h048, 16'h0203};
			67: return {9'h028, 16'h0003};
			68: return {9'h030, 16'h0001};
			69: return {9'h070, MODE_PARALLEL ? 16'h0000 : 16'h0007};
			70: return {9'h0C0, p192 | 16'h0001};
			default: return ssu_pkg::SSU_SEQ[i];
		endcase
	endfunction : exp_wr

	task automatic check(input logic [24:0] s, input logic [24:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check

	task automatic wrap_up();
		$display("comparisons=%0d mismatches=%0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	// Every completed write frame is compared with the next expected upload
	// The model's own start-up value of the toggle must not count as a frame
	always @(wr_tgl) if (!SYS_RST) begin
		check({wr_addr, wr_data}, stopping ? {9'h0C0, p192} : exp_wr(wi));
		if (wi == 0 && !stopping) check({24'h0, lock_seen}, {24'h0, MODE_PLL & ~MODE_PARALLEL});
		wi++;
	end

	task automatic do_reset();
		SYS_RST = 1'h1;
		seed = xs();
		p129 = seed[15:0];
		seed = xs();
		p192 = seed[15:0] & 16'hFFFE;
		lk = seed[17:16];
		repeat (20) @(negedge CLK);
		SYS_RST = 1'h0;
		wi = 0;
	endtask : do_reset

	task automatic wait_done(input int lim);
		int n;
		for (n = 0; n < lim && DONE !== 1'h1; n++) @(negedge CLK);
		if (n == lim) begin
			fails++;
			wrap_up();
		end
	endtask : wait_done

	// Kind 1 repeats START while busy, kind 2 cuts the run with a reset
	task automatic run(input logic m8, input logic pll, input logic par, input int kind);
		do_reset();
		MODE_8BIT = m8;
		MODE_PLL = pll;
		MODE_PARALLEL = par;
		START = 1'h1;
		@(negedge CLK);
		START = 1'h0;
		repeat (3000) @(negedge CLK);
		check({24'h0, BUSY}, 25'h1);
		if (kind == 2) begin
			SYS_RST = 1'h1;
			@(negedge CLK);
			check({20'h0, BUSY, RUNNING, SPI_SS_N, SPI_SCLK, SPI_MOSI}, 25'h4);
			$display("test reset mid run done");
			return;
		end
		START = kind[0];
		@(negedge CLK);
		START = 1'h0;
		wait_done(25000);
		check(25'(wi), 25'd71);
		check({22'h0, RUNNING, seq_on, width8}, {22'h0, 2'h3, m8});
		check({17'h0, polls}, {17'h0, (pll & ~par) ? {6'h0, lk} + 8'h1 : 8'h0});
		stopping = 1'h1;
		STOP = 1'h1;
		@(negedge CLK);
		STOP = 1'h0;
		wait_done(2000);
		@(negedge CLK);
		stopping = 1'h0;
		check(25'(wi), 25'd72);
		check({23'h0, RUNNING, seq_on}, 25'h0);
		$display("test run m8=%b pll=%b par=%b done", m8, pll, par);
	endtask : run

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		int n;
		do_reset();
		STOP = 1'h1;
		@(negedge CLK);
		STOP = 1'h0;
		MODE_8BIT = 1'h1;
		MODE_PARALLEL = 1'h1;
		START = 1'h1;
		@(negedge CLK);
		START = 1'h0;
		for (n = 0; n < 4 && ERR !== 1'h1; n++) @(negedge CLK);
		check({24'h0, ERR}, 25'h1);
		repeat (300) @(negedge CLK);
		check({wi[23:0], BUSY}, 25'h0);
		$display("test refusals done");
		run(1'h0, 1'h1, 1'h0, 2);
		run(1'h1, 1'h1, 1'h0, 1);
		run(1'h1, 1'h0, 1'h0, 0);
		run(1'h0, 1'h1, 1'h0, 0);
		run(1'h0, 1'h0, 1'h0, 0);
		run(1'h0, 1'h0, 1'h1, 0);
		wrap_up();
	end
endmodule : ssu_loader_test
